// ---- sld_cfg.svh ----
// Constants for the serial latched display driver
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH
`define SLD_STAGES      32
`define SLD_SHIFT_RESET 32'h0000_0000
`define SLD_LATCH_RESET 32'h0000_0000
`endif

// ---- sld_host.sv ----
// Host model that shifts serial words into the driver
`timescale 1ns/10ps
module sld_host (
    input  wire logic clk,
    output logic      shift_clk,
    output logic      ser_in
);
    // Idle shift clock stands low between words
    initial begin
        shift_clk = 1'h0;
        ser_in    = 1'h0;
    end
    // Data is set a full cycle before the rising shift edge
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            @(posedge clk) #1 ser_in = w[i];
            shift_clk = 1'h0;
            @(posedge clk) #1 shift_clk = 1'h1;
        end
        @(posedge clk) #1 shift_clk = 1'h0;
        ser_in = ~ser_in; // Released line must not look held
    endtask
endmodule

// ---- sld_pkg.sv ----
// Types for the serial latched display driver
`include "sld_cfg.svh"
package sld_pkg;
    typedef logic [`SLD_STAGES-1:0] sld_word_type;
    typedef struct packed {
        logic shift_edge;
        logic ser_in;
        logic strobe;
        logic blank;
    } sld_ctrl_type;
    typedef struct packed {
        logic         ser_out;
        sld_word_type drive;
    } sld_out_type;
endpackage

// ---- sld_shift.sv ----
// Serial-in shift register with edge detect on the shift clock
`timescale 1ns/10ps
`include "sld_cfg.svh"
module sld_shift #(
    parameter int STAGES = `SLD_STAGES
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              shift_clk,
    input  wire logic              ser_in,
    output logic [STAGES-1:0]      stages,
    output logic                   rise
);
    logic              shift_clk_q;
    logic              next_shift_clk_q;
    logic [STAGES-1:0] next_stages;

    // Rising edge of the shift clock, taken as synchronous to CLK
    assign rise = shift_clk & ~shift_clk_q;

    // New bit enters stage 0, older bits move toward the last stage
    always_comb begin
        next_shift_clk_q = shift_clk;
        next_stages      = stages;
        if (rise) begin
            next_stages = {stages[STAGES-2:0], ser_in};
        end
    end

    // Register stage; CE low freezes everything
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_clk_q <= 1'b0;
            stages      <= STAGES'(`SLD_SHIFT_RESET);
        end else if (ce) begin
            shift_clk_q <= next_shift_clk_q;
            stages      <= next_stages;
        end
    end
endmodule

// ---- sld_top.sv ----
// Serial latched display driver: shift, latch and blanking stages
// Contract
// - A rising shift-clock edge captures serial input into the first stage.
// - Each later rising edge moves every stage one place toward serial out.
// - Shift register and latches hold 32 stages; stage N drives output N.
// - Last shift stage drives serial output for cascading devices.
// - Strobe high makes latches transparent, tracking the shift stages.
// - Strobe low makes latches hold their stored value.
// - Blanking high drives every DRIVE output low; serial output is not blanked.
// - Blanking never changes latch contents.
// - Blanking low lets each output follow its own latch.
// - Serial output shows the last shift stage one clock cycle later.
`timescale 1ns/10ps
`include "sld_cfg.svh"
module sld_top #(
    parameter int STAGES = `SLD_STAGES
) (
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic              CE,
    input  wire logic              SHIFT_CLK,
    input  wire logic              SER_IN,
    input  wire logic              STROBE,
    input  wire logic              BLANK,
    output logic                   SER_OUT,
    output logic [STAGES-1:0]      DRIVE
);
    logic [STAGES-1:0] stages;
    logic              rise;
    logic [STAGES-1:0] latch;
    logic [STAGES-1:0] next_latch;
    logic [STAGES-1:0] next_drive;
    logic              next_ser_out;

    sld_pkg::sld_ctrl_type ctrl;

    // Pin inputs travel as one bundle; SHIFT_CLK is a plain synchronous
    // level here, its rising edge is found inside the shift stage
    assign ctrl = '{
        shift_edge: SHIFT_CLK,
        ser_in:     SER_IN,
        strobe:     STROBE,
        blank:      BLANK
    };

    // One stage per output driver
    sld_shift #(.STAGES(STAGES)) u_shift (
        .clk       (CLK),
        .rst       (RST),
        .ce        (CE),
        .shift_clk (ctrl.shift_edge),
        .ser_in    (ctrl.ser_in),
        .stages    (stages),
        .rise      (rise)
    );

    // Per-bit latch, transparent to the shift stage while strobe is high;
    // blanking is not read here so stored data survives it
    always_comb begin
        for (int i = 0; i < STAGES; i++) begin
            next_latch[i] = ctrl.strobe ? stages[i] : latch[i];
        end
    end

    // Output stage: blanking forces low, else follow the latch. Outputs are
    // computed from next_latch so strobe and data land in the same cycle.
    always_comb begin
        next_ser_out = stages[STAGES-1];
        for (int i = 0; i < STAGES; i++) begin
            next_drive[i] = ctrl.blank ? 1'b0 : next_latch[i];
        end
    end

    // Register all state; CE low freezes it
    always_ff @(posedge CLK) begin
        if (RST) begin
            latch   <= STAGES'(`SLD_LATCH_RESET);
            DRIVE   <= STAGES'(`SLD_LATCH_RESET);
            SER_OUT <= 1'b0;
        end else if (CE) begin
            latch   <= next_latch;
            DRIVE   <= next_drive;
            SER_OUT <= next_ser_out;
        end
    end

    // Serial output follows the last stage one cycle later
    property p_ser_out;
        @(posedge CLK) disable iff (RST)
        CE |=> SER_OUT == $past(stages[STAGES-1]);
    endproperty
    a_ser_out: assert property (p_ser_out)
        else $error("serial out does not follow last stage");

    // Capture into stage 0 on a shift clock edge
    property p_capture;
        @(posedge CLK) disable iff (RST)
        (CE && rise) |=> stages[0] == $past(SER_IN);
    endproperty
    a_capture: assert property (p_capture)
        else $error("serial bit not captured");

    // Shift moves data one place
    property p_shift;
        @(posedge CLK) disable iff (RST)
        (CE && rise) |=> stages[STAGES-1:1] == $past(stages[STAGES-2:0]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("shift register did not advance");

    // No edge, no movement
    property p_no_shift;
        @(posedge CLK) disable iff (RST)
        (CE && !rise) |=> $stable(stages);
    endproperty
    a_no_shift: assert property (p_no_shift)
        else $error("shift register moved without edge");

    // Transparent latch while strobe is high
    property p_transp;
        @(posedge CLK) disable iff (RST)
        (CE && STROBE) |=> latch == $past(stages);
    endproperty
    a_transp: assert property (p_transp)
        else $error("latch not transparent");

    // Hold while strobe low, whatever blanking does
    property p_hold;
        @(posedge CLK) disable iff (RST)
        (CE && !STROBE) |=> $stable(latch);
    endproperty
    a_hold: assert property (p_hold)
        else $error("latch changed with strobe low");

    // Blanking forces outputs low
    property p_blank;
        @(posedge CLK) disable iff (RST)
        (CE && BLANK) |=> DRIVE == '0;
    endproperty
    a_blank: assert property (p_blank)
        else $error("outputs not low while blanked");

    // Unblanked outputs match latches
    property p_follow;
        @(posedge CLK) disable iff (RST)
        (CE && !BLANK) |=> DRIVE == latch;
    endproperty
    a_follow: assert property (p_follow)
        else $error("outputs do not follow latches");

    // Blanking then release shows the unchanged latch pattern
    sequence s_blank_hold;
        (CE && BLANK && !STROBE) ##1 (CE && !BLANK && !STROBE);
    endsequence
    property p_unblank;
        @(posedge CLK) disable iff (RST)
        s_blank_hold |=> DRIVE == $past(latch, 2);
    endproperty
    a_unblank: assert property (p_unblank)
        else $error("latch data lost across blanking");

    // Without an edge the serial output already equals the last stage
    property p_ser_out_quiet;
        @(posedge CLK) disable iff (RST)
        (CE && !rise) |=> SER_OUT == stages[STAGES-1];
    endproperty
    a_ser_out_quiet: assert property (p_ser_out_quiet)
        else $error("serial out differs from last stage");

    // Two edges two cycles apart stack the bits in arrival order
    sequence s_two_edges;
        (CE && rise) ##2 (CE && rise);
    endsequence
    property p_two_edges;
        @(posedge CLK) disable iff (RST)
        s_two_edges |=> stages[1:0] == {$past(SER_IN, 3), $past(SER_IN)};
    endproperty
    a_two_edges: assert property (p_two_edges)
        else $error("serial bits stacked in wrong order");

    // One host pulse is one edge, so data moves once per pulse
    property p_rise_once;
        @(posedge CLK) disable iff (RST)
        (CE && rise) |=> !rise;
    endproperty
    a_rise_once: assert property (p_rise_once)
        else $error("one shift clock pulse seen as two edges");

    // Strobe with outputs enabled shows the shift stages next cycle
    property p_strobe_show;
        @(posedge CLK) disable iff (RST)
        (CE && STROBE && !BLANK) |=> DRIVE == $past(stages);
    endproperty
    a_strobe_show: assert property (p_strobe_show)
        else $error("strobed data not shown on outputs");

    // Blanked while transparent: outputs low, latches still track
    property p_blank_track;
        @(posedge CLK) disable iff (RST)
        (CE && BLANK && STROBE) |=> DRIVE == '0 && latch == $past(stages);
    endproperty
    a_blank_track: assert property (p_blank_track)
        else $error("blanking disturbed latch tracking");

    // Two quiet cycles leave the outputs where they were
    sequence s_quiet;
        CE && !STROBE && !BLANK;
    endsequence
    property p_drive_hold;
        @(posedge CLK) disable iff (RST)
        s_quiet ##1 s_quiet |=> $stable(DRIVE);
    endproperty
    a_drive_hold: assert property (p_drive_hold)
        else $error("outputs moved with strobe and blanking low");

    // CE low freezes every register; a stalled host sees no change
    property p_freeze;
        @(posedge CLK) disable iff (RST)
        !CE |=> $stable(stages) && $stable(latch) && $stable(DRIVE)
            && $stable(SER_OUT);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state changed with enable low");

    // Reset clears shift stages, latches and outputs whatever CE does
    property p_reset;
        @(posedge CLK)
        RST |=> stages == STAGES'(`SLD_SHIFT_RESET)
            && latch == STAGES'(`SLD_LATCH_RESET)
            && DRIVE == STAGES'(`SLD_LATCH_RESET) && !SER_OUT;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset did not clear the block");
endmodule

// ---- sld_top_tb.sv ----
// Self-checking bench for the serial latched display driver
`timescale 1ns/10ps
module sld_top_tb;
    logic        clk, rst, ce, strobe, blank, shift_clk, ser_in, ser_out;
    logic [31:0] drive;
    int          n_fail, n_compared, cyc;
    // Rows: blanking, word shifted in, drive expected after strobe
    logic [64:0] rows [3] = '{
        {1'h0, 32'h8000_0001, 32'h8000_0001},
        {1'h0, 32'hA5C3_0F96, 32'hA5C3_0F96},
        {1'h1, 32'hFFFF_FFFF, 32'h0000_0000}};
    sld_top uut (.CLK(clk), .RST(rst), .CE(ce), .SHIFT_CLK(shift_clk),
        .SER_IN(ser_in), .STROBE(strobe), .BLANK(blank),
        .SER_OUT(ser_out), .DRIVE(drive));
    sld_host host (.clk(clk), .shift_clk(shift_clk), .ser_in(ser_in));
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (!ok) begin
            n_fail++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask
    // One-cycle strobe, then let the registered outputs settle
    task automatic latch_now();
        @(posedge clk) #1 strobe = 1'h1;
        @(posedge clk) #1 strobe = 1'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Clock at 4 ns period
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // Ceiling far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            final_report();
        end
    end
    // Main sequence: table rows, then hold, tracking, enable and reset cases
    initial begin
        rst = 1'h1;
        ce = 1'h1;
        strobe = 1'h0;
        blank = 1'h0;
        repeat (3) @(posedge clk);
        #1 rst = 1'h0;
        chk(drive === 32'h0 && ser_out === 1'h0, "reset outputs");
        foreach (rows[i]) begin
            blank = rows[i][64];
            host.send(rows[i][63:32]);
            latch_now();
            chk(drive === rows[i][31:0], "drive");
            chk(ser_out === rows[i][63], "serial out");
            $display("Row %0d done", i);
        end
        blank = 1'h0;
        repeat (2) @(posedge clk);
        #1 chk(drive === 32'hFFFF_FFFF, "latch after blank");
        host.send(32'h1234_5678);
        repeat (2) @(posedge clk);
        #1 chk(drive === 32'hFFFF_FFFF, "hold, strobe low");
        chk(ser_out === 1'h0, "serial out after hold");
        $display("Hold test done");
        blank = 1'h1;
        strobe = 1'h1;
        host.send(32'h0F0F_00FF);
        chk(drive === 32'h0, "blank while tracking");
        blank = 1'h0;
        repeat (2) @(posedge clk);
        #1 chk(drive === 32'h0F0F_00FF, "tracking strobe");
        strobe = 1'h0;
        $display("Tracking test done");
        // Enable low: a whole word of shift pulses must be ignored
        ce = 1'h0;
        blank = 1'h1;
        host.send(32'hFFFF_FFFF);
        chk(drive === 32'h0F0F_00FF && ser_out === 1'h0, "enable low froze");
        ce = 1'h1;
        blank = 1'h0;
        latch_now();
        chk(drive === 32'h0F0F_00FF, "no shift while enable low");
        $display("Enable test done");
        rst = 1'h1;
        repeat (2) @(posedge clk);
        #1 chk(drive === 32'h0 && ser_out === 1'h0, "mid-run reset");
        rst = 1'h0;
        $display("Reset test done");
        final_report();
    end
endmodule
